// file: core/fcl_map.svh
// Purpose: Offsets, field positions, reset values and counts of the loader
// Assumes: Included by the loader modules by bare name
// Notes: Byte address of a register is four times its index
`ifndef FCL_MAP_SVH
`define FCL_MAP_SVH

// Register indices
`define FCL_IDX_WDT 4'h0
`define FCL_IDX_BOD 4'h1
`define FCL_IDX_OSC 4'h2
`define FCL_IDX_CMP 4'h4
`define FCL_IDX_SYSA 4'h5
`define FCL_IDX_SUT 4'h6
`define FCL_IDX_APP_SECTION_END_FUSE 4'h7
`define FCL_IDX_BOOT_SECTION_END_FUSE 4'h8
`define FCL_IDX_LOCK 4'hA
`define FCL_IDX_STATUS 4'hC

// Field positions
`define FCL_WDT_WIN 7:4
`define FCL_WDT_PER 3:0
`define FCL_BOD_LVL 7:5
`define FCL_BOD_RATE 4
`define FCL_BOD_ACT 3:2
`define FCL_BOD_SLP 1:0
`define FCL_OSC_LOCK 7
`define FCL_OSC_FSEL 1:0
`define FCL_CMP_EN 7:4
`define FCL_CMP_LVL 3:0
`define FCL_SYS_CRC 7:6
`define FCL_SYS_PIN 3:2
`define FCL_SYS_EEPROM_KEEP_ON_ERASE 0
`define FCL_SUT_CODE 2:0

// Codes and reset values
`define FCL_FUSE_RST 8'h00
`define FCL_LOCK_KEY 8'hC5
`define FCL_FSEL_16M 2'h1
`define FCL_FSEL_20M 2'h2
`define FCL_CRC_NONE 2'h3
`define FCL_CAL_RST 16'h0000

// Timing
`define FCL_CLK_NS 20
`define FCL_MS_NS 1000000
`define FCL_GUARD_CYCLES 10'd768

`endif

// file: core/fcl_pkg.sv
// Purpose: Types shared by the fuse configuration loader
// Assumes: Constants live in fcl_map.svh
// Notes: State codes are one-hot
package fcl_pkg;
  typedef logic [7:0] fcl_byte_t;
  typedef fcl_byte_t [10:0] fcl_bank_t;
  typedef enum logic [2:0] {
    FCL_LOAD = 3'b001,
    FCL_WAIT = 3'b010,
    FCL_RUN = 3'b100
  } fcl_state_t;
  typedef enum logic [1:0] {
    FCL_PIN_GPIO = 2'h0,
    FCL_PIN_DEBUG = 2'h1,
    FCL_PIN_RESET = 2'h2,
    FCL_PIN_RSVD = 2'h3
  } fcl_pin_role_t;
endpackage : fcl_pkg

// file: core/fcl_guard_if.sv
// Purpose: Link between loader top and reset-pin guard timer
// Assumes: Single clock domain on both sides
// Notes: role_gpio is a level, active is a level
interface fcl_guard_if;
  logic role_gpio; // Pin configured as general I/O
  logic active; // Output driver still held off
  modport top (output role_gpio, input active);
  modport guard (input role_gpio, output active);
endinterface : fcl_guard_if

// file: core/fcl_guard.sv
// Purpose: Holds the reset pin driver off for 768 slow oscillator cycles
// Assumes: slow_osc is asynchronous to pclk and much slower
// Notes: Counting starts at reset release
`include "fcl_map.svh"
module fcl_guard
  import fcl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow_osc,
  fcl_guard_if.guard gif
);
  logic s1_q; // First sync stage, read only by s2
  logic s2_q; // Second sync stage
  logic s3_q; // Third sync stage
  logic stable_q; // Agreed slow clock level
  logic [9:0] cnt_q; // Slow cycles seen
  logic active_q; // Guard state
  logic agree; // Stages two and three match
  logic rise; // Agreed level rises
  logic done; // Guard period over

  assign agree = (s2_q == s3_q);
  assign rise = agree && s3_q && !stable_q;
  assign done = (cnt_q == `FCL_GUARD_CYCLES);
  assign gif.active = active_q;

  // Three-stage synchroniser and filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      stable_q <= 1'b0;
    end else begin
      s1_q <= slow_osc;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        stable_q <= s3_q;
      end
    end
  end

  // Count slow cycles, hold driver off until done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 10'h000;
      active_q <= 1'b1;
    end else begin
      if (rise && !done) begin
        cnt_q <= cnt_q + 10'h001; // R14
      end
      // Held from reset on, so the first loaded cycle cannot open the driver
      active_q <= !(done && gif.role_gpio); // R14
    end
  end
endmodule : fcl_guard

// file: core/fcl_top.sv
// Purpose: Copies fuse bytes into peripheral controls at reset, APB view
// Assumes: Fuse bank and factory calibration are stable around reset
// Notes: One APB wait state on every access
//
// Operation
// [R1] Watchdog window from fuse bits 7:4
// [R2] Watchdog period from fuse bits 3:0
// [R3] Brown-out level from fuse bits 7:5
// [R4] Brown-out sample rate from bit 4
// [R5] Active brown-out mode from bits 3:2
// [R6] Sleep brown-out mode from bits 1:0
// [R7] Oscillator bit 7 locks calibration registers
// [R8] Frequency select loads matching factory calibration
// [R9] Timer fuse byte copied to fault control
// [R10] Bits 7:4 enable compare pin outputs
// [R11] Bits 3:0 give compare default levels
// [R12] CRC source selects scanned flash range
// [R13] Reset pin role: I/O, debug, reset
// [R14] I/O role: driver off 768 slow cycles
// [R15] Software enables pin interrupts after guard
// [R16] EEPROM save bit keeps EEPROM on erase
// [R17] Locked device always erases EEPROM
// [R18] Start-up field sets delay before execution
// [R19] Only key C5 unlocks memory access
// [R20] Fuses sampled once, fixed until reset; the lock key copy stays writable by software
//
// Local design decision: the APB slave port.
`include "fcl_map.svh"
module fcl_top
  import fcl_pkg::*;
#(
  parameter int MS_CYCLES = `FCL_MS_NS / `FCL_CLK_NS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fcl_bank_t fuse_bank,
  input wire logic [15:0] factory_cal_16m,
  input wire logic [15:0] factory_cal_20m,
  input wire logic slow_osc,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic [3:0] wdt_window,
  output logic [3:0] wdt_period,
  output logic [2:0] brownout_threshold,
  output logic brownout_sample_rate,
  output logic [1:0] brownout_active_mode,
  output logic [1:0] brownout_sleep_mode,
  output logic calibration_lock,
  output logic [1:0] oscillator_frequency_select,
  output logic [7:0] coarse_calibration,
  output logic [7:0] temperature_calibration,
  output logic [7:0] fault_control_reg,
  output logic [3:0] compare_pin_enable,
  output logic [3:0] compare_default_level,
  output logic [1:0] crc_source_select,
  output logic crc_scan_enable,
  output logic [1:0] reset_pin_role,
  output logic [7:0] boot_section_end,
  output logic [7:0] app_section_end,
  output logic memory_unlocked,
  output logic eeprom_keep_on_erase,
  output logic core_release
);

  // Start-up delay in milliseconds for a code
  function automatic logic [6:0] sut_ms(input logic [2:0] code);
    logic [6:0] ms;
    ms = 7'h00;
    if (code != 3'h0) begin
      ms = 7'h01 << (code - 3'h1);
    end
    return ms;
  endfunction : sut_ms

  // Calibration pair for a frequency code
  function automatic logic [15:0] cal_pick(
    input logic [1:0] fsel,
    input logic [15:0] cal16,
    input logic [15:0] cal20
  );
    logic [15:0] cal;
    cal = cal20;
    if (fsel == `FCL_FSEL_16M) begin
      cal = cal16;
    end
    return cal;
  endfunction : cal_pick

  // Fuse shadows, loaded once after reset; lock_q also software-written, lock decodes updated every cycle
  fcl_byte_t wdt_q; // Watchdog fuse
  fcl_byte_t bod_q; // Brown-out fuse
  fcl_byte_t osc_q; // Oscillator fuse
  fcl_byte_t cmp_q; // Compare output fuse
  fcl_byte_t sysa_q; // System fuse A
  fcl_byte_t sut_q; // Start-up fuse
  fcl_byte_t app_section_end_fuse_q; // Application end fuse
  fcl_byte_t boot_section_end_fuse_q; // Boot end fuse
  fcl_byte_t lock_q; // Lock key fuse
  logic [15:0] cal_q; // Chosen calibration pair
  logic unlocked_q; // Lock key matches
  logic eekeep_q; // EEPROM kept on erase

  // Sequencer
  fcl_state_t state_q; // Load sequencer state
  fcl_state_t state_d; // Next state
  logic [31:0] tick_q; // Cycles within a millisecond
  logic [6:0] ms_q; // Milliseconds waited
  logic release_q; // Core running
  logic ms_tick; // Millisecond boundary
  logic wait_done; // Start-up delay elapsed

  // Reset pin
  logic pin_out_q; // Pin level
  logic pin_oe_q; // Pin driver enable
  logic role_gpio; // Pin configured as I/O

  // APB
  logic [31:0] prdata_q; // Read data
  logic pready_q; // Access answer
  logic pslverr_q; // Access error
  logic [3:0] idx; // Register index
  logic in_range; // Address inside block
  logic idx_hit; // Index names a register
  logic is_lock; // Lock key selected
  logic access; // Access phase, not yet answered
  logic wr_lock; // Lock key write taken
  logic bad; // Access to be refused
  logic [7:0] rd_byte; // Selected register value

  fcl_guard_if gif ();

  // Guard timer for the reset pin driver
  fcl_guard u_guard (
    .pclk(pclk),
    .presetn(presetn),
    .slow_osc(slow_osc),
    .gif(gif)
  );

  // Fuse fields onto peripheral controls
  assign wdt_window = wdt_q[`FCL_WDT_WIN]; // R1
  assign wdt_period = wdt_q[`FCL_WDT_PER]; // R2
  assign brownout_threshold = bod_q[`FCL_BOD_LVL]; // R3
  assign brownout_sample_rate = bod_q[`FCL_BOD_RATE]; // R4
  assign brownout_active_mode = bod_q[`FCL_BOD_ACT]; // R5
  assign brownout_sleep_mode = bod_q[`FCL_BOD_SLP]; // R6
  assign calibration_lock = osc_q[`FCL_OSC_LOCK]; // R7
  assign oscillator_frequency_select = osc_q[`FCL_OSC_FSEL]; // R8
  assign coarse_calibration = cal_q[7:0]; // R8
  assign temperature_calibration = cal_q[15:8]; // R8
  assign fault_control_reg = cmp_q; // R9
  assign compare_pin_enable = cmp_q[`FCL_CMP_EN]; // R10
  assign compare_default_level = cmp_q[`FCL_CMP_LVL]; // R11
  assign crc_source_select = sysa_q[`FCL_SYS_CRC]; // R12
  assign reset_pin_role = sysa_q[`FCL_SYS_PIN]; // R13
  assign boot_section_end = boot_section_end_fuse_q;
  assign app_section_end = app_section_end_fuse_q;
  assign memory_unlocked = unlocked_q;
  assign eeprom_keep_on_erase = eekeep_q;
  assign core_release = release_q;
  assign reset_pin_out = pin_out_q;
  assign reset_pin_oe = pin_oe_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // CRC scan runs unless no-check code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_scan_enable <= 1'b0;
    end else begin
      crc_scan_enable <= (state_q != FCL_LOAD) &&
                         (sysa_q[`FCL_SYS_CRC] != `FCL_CRC_NONE); // R12
    end
  end

  // Pin role decode and guard hand-off
  assign role_gpio = (sysa_q[`FCL_SYS_PIN] == FCL_PIN_GPIO) && (state_q != FCL_LOAD);
  assign gif.role_gpio = role_gpio;

  // Start-up delay timing
  assign ms_tick = (tick_q == 32'(MS_CYCLES - 1));
  assign wait_done = (ms_q >= sut_ms(sut_q[`FCL_SUT_CODE]));

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      FCL_LOAD: begin
        state_d = FCL_WAIT;
      end
      FCL_WAIT: begin
        if (wait_done) begin
          state_d = FCL_RUN; // R18
        end
      end
      FCL_RUN: begin
        state_d = FCL_RUN;
      end
      default: begin
        state_d = FCL_LOAD;
      end
    endcase
  end

  // Sequencer state and core release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= FCL_LOAD;
      release_q <= 1'b0;
    end else begin
      state_q <= state_d;
      release_q <= (state_d == FCL_RUN); // R18
    end
  end

  // Millisecond counter during start-up wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 32'h00000000;
      ms_q <= 7'h00;
    end else if (state_q == FCL_WAIT) begin
      if (ms_tick) begin
        tick_q <= 32'h00000000;
        ms_q <= ms_q + 7'h01; // R18
      end else begin
        tick_q <= tick_q + 32'h00000001;
      end
    end
  end

  // Capture fuses once, right after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_q <= `FCL_FUSE_RST;
      bod_q <= `FCL_FUSE_RST;
      osc_q <= `FCL_FUSE_RST;
      cmp_q <= `FCL_FUSE_RST;
      sysa_q <= `FCL_FUSE_RST;
      sut_q <= `FCL_FUSE_RST;
      app_section_end_fuse_q <= `FCL_FUSE_RST;
      boot_section_end_fuse_q <= `FCL_FUSE_RST;
      cal_q <= `FCL_CAL_RST;
    end else if (state_q == FCL_LOAD) begin
      wdt_q <= fuse_bank[`FCL_IDX_WDT]; // R20
      bod_q <= fuse_bank[`FCL_IDX_BOD];
      osc_q <= fuse_bank[`FCL_IDX_OSC];
      cmp_q <= fuse_bank[`FCL_IDX_CMP];
      sysa_q <= fuse_bank[`FCL_IDX_SYSA];
      sut_q <= fuse_bank[`FCL_IDX_SUT];
      app_section_end_fuse_q <= fuse_bank[`FCL_IDX_APP_SECTION_END_FUSE];
      boot_section_end_fuse_q <= fuse_bank[`FCL_IDX_BOOT_SECTION_END_FUSE];
      cal_q <= cal_pick(fuse_bank[`FCL_IDX_OSC][`FCL_OSC_FSEL],
                        factory_cal_16m, factory_cal_20m); // R8
    end
  end

  // Lock key: loaded at reset, software may rewrite it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= `FCL_FUSE_RST;
    end else if (state_q == FCL_LOAD) begin
      lock_q <= fuse_bank[`FCL_IDX_LOCK];
    end else if (wr_lock) begin
      lock_q <= pwdata[7:0];
    end
  end

  // Lock decode and chip-erase EEPROM policy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlocked_q <= 1'b0;
      eekeep_q <= 1'b0;
    end else begin
      unlocked_q <= (lock_q == `FCL_LOCK_KEY); // R19
      eekeep_q <= (lock_q == `FCL_LOCK_KEY) &&
                  sysa_q[`FCL_SYS_EEPROM_KEEP_ON_ERASE]; // R16 R17
    end
  end

  // Reset pin driver, held off while guard runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_out_q <= gpio_out;
      pin_oe_q <= gpio_oe && role_gpio && !gif.active; // R13 R14
    end
  end

  // APB decode
  assign idx = paddr[5:2];
  assign in_range = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0);
  assign idx_hit = (idx <= `FCL_IDX_BOOT_SECTION_END_FUSE && idx != 4'h3) ||
                   idx == `FCL_IDX_LOCK || idx == `FCL_IDX_STATUS;
  assign is_lock = (idx == `FCL_IDX_LOCK);
  assign access = psel && penable && !pready_q;
  assign bad = !in_range || !idx_hit || (pwrite && !is_lock);
  assign wr_lock = access && pwrite && !bad && (state_q != FCL_LOAD);

  // Read data selection
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      `FCL_IDX_WDT: rd_byte = wdt_q;
      `FCL_IDX_BOD: rd_byte = bod_q;
      `FCL_IDX_OSC: rd_byte = osc_q;
      `FCL_IDX_CMP: rd_byte = cmp_q;
      `FCL_IDX_SYSA: rd_byte = sysa_q;
      `FCL_IDX_SUT: rd_byte = sut_q;
      `FCL_IDX_APP_SECTION_END_FUSE: rd_byte = app_section_end_fuse_q;
      `FCL_IDX_BOOT_SECTION_END_FUSE: rd_byte = boot_section_end_fuse_q;
      `FCL_IDX_LOCK: rd_byte = lock_q;
      `FCL_IDX_STATUS: rd_byte = {4'h0, gif.active, unlocked_q,
                                  release_q, (state_q != FCL_LOAD)};
      default: rd_byte = 8'h00;
    endcase
  end

  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (access) begin
      pready_q <= 1'b1;
      pslverr_q <= bad;
      prdata_q <= (pwrite || bad) ? 32'h00000000 : {24'h000000, rd_byte};
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end
endmodule : fcl_top

// file: verification/fcl_fuse_model.sv
// Purpose: Fuse store, factory pair and slow oscillator for the loader
// Assumes: Bench sets the whole bank at each reset, later rewrites byte 0 alone
// Notes: Slow clock sped up, toggles on odd ns away from pclk edges
module fcl_fuse_model
  import fcl_pkg::*;
#(
  parameter logic [15:0] CAL16 = 16'h3C21,
  parameter logic [15:0] CAL20 = 16'h4D32
)
(
  input wire logic pclk,
  input wire fcl_bank_t bank_in,
  output fcl_bank_t fuse_bank,
  output logic [15:0] factory_cal_16m,
  output logic [15:0] factory_cal_20m,
  output logic slow_osc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] junk_q = 8'h5A; // Changing pattern for unused bytes
  assign factory_cal_16m = CAL16;
  assign factory_cal_20m = CAL20;
  // Unused bytes never hold a stale value
  always @(posedge pclk) junk_q <= junk_q + 8'h01;
  always_comb begin
    fuse_bank = bank_in;
    fuse_bank[3] = junk_q;
    fuse_bank[9] = ~junk_q;
  end
  // Free-running slow oscillator, phase unrelated to pclk
  initial begin
    slow_osc = 1'b0;
    #1;
    // Each level spans at least two pclk edges, so the pin filter agrees
    forever #42 slow_osc = ~slow_osc;
  end
endmodule : fcl_fuse_model

// file: verification/fcl_top_properties.sv
// Purpose: Port-level checks of the fuse configuration loader
// Assumes: Fuse bank steady from reset until core release
// Notes: Bound to the loader from the bench top file
module fcl_top_properties
  import fcl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic penable,
  input wire logic pready,
  input wire fcl_bank_t fuse_bank,
  input wire logic [15:0] factory_cal_16m,
  input wire logic [15:0] factory_cal_20m,
  input wire logic slow_osc,
  input wire logic reset_pin_oe,
  input wire logic [1:0] reset_pin_role,
  input wire logic [3:0] wdt_window,
  input wire logic [3:0] wdt_period,
  input wire logic [2:0] brownout_threshold,
  input wire logic brownout_sample_rate,
  input wire logic [1:0] brownout_active_mode,
  input wire logic [1:0] brownout_sleep_mode,
  input wire logic calibration_lock,
  input wire logic [1:0] oscillator_frequency_select,
  input wire logic [7:0] coarse_calibration,
  input wire logic [7:0] temperature_calibration,
  input wire logic [7:0] fault_control_reg,
  input wire logic [3:0] compare_pin_enable,
  input wire logic [3:0] compare_default_level,
  input wire logic [1:0] crc_source_select,
  input wire logic crc_scan_enable,
  input wire logic memory_unlocked,
  input wire logic eeprom_keep_on_erase,
  input wire logic core_release
);
  timeunit 1ns;
  timeprecision 1ns;
  logic slow_q; // Last sampled slow clock
  logic [9:0] slow_cnt_q; // Slow rises since reset, saturating
  logic [9:0] slow_cnt_d;
  wire slow_rise = slow_osc && !slow_q;
  assign slow_cnt_d = (slow_rise && slow_cnt_q != 10'h3FF) ? slow_cnt_q + 10'h001 : slow_cnt_q;
  // Count slow clock rises, never fewer than the loader sees
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_q <= 1'b0;
      slow_cnt_q <= 10'h000;
    end else begin
      slow_q <= slow_osc;
      slow_cnt_q <= slow_cnt_d;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  chk_one_wait: assert property (penable && !pready |=> pready)
    else $error("answer late");
  chk_wdt_fields: assert property ($rose(core_release) |->
    wdt_window == fuse_bank[0][7:4] && wdt_period == fuse_bank[0][3:0])
    else $error("watchdog fields wrong");
  chk_bod_fields: assert property ($rose(core_release) |->
    {brownout_threshold, brownout_sample_rate, brownout_active_mode,
     brownout_sleep_mode} == fuse_bank[1])
    else $error("brown-out fields wrong");
  chk_osc_pair: assert property ($rose(core_release) |->
    calibration_lock == fuse_bank[2][7] && oscillator_frequency_select == fuse_bank[2][1:0]
    && {temperature_calibration, coarse_calibration} ==
    (fuse_bank[2][1:0] == 2'h1 ? factory_cal_16m : factory_cal_20m))
    else $error("oscillator fields wrong");
  chk_fault_copy: assert property ($rose(core_release) |->
    fault_control_reg == fuse_bank[4] &&
    {compare_pin_enable, compare_default_level} == fuse_bank[4])
    else $error("compare fields wrong");
  chk_crc_scan: assert property ($rose(core_release) |=>
    crc_source_select == fuse_bank[5][7:6] && crc_scan_enable == (crc_source_select != 2'h3))
    else $error("scan select wrong");
  chk_guard_hold: assert property (reset_pin_oe |->
    reset_pin_role == 2'h0 && slow_cnt_q >= 10'h300)
    else $error("pin driven during guard");
  chk_locked_erase: assert property (!memory_unlocked [*2] ##0 core_release |->
    !eeprom_keep_on_erase)
    else $error("locked part keeps eeprom");
  chk_fields_fixed: assert property (core_release && $past(core_release) |->
    $stable(wdt_window) && $stable(fault_control_reg))
    else $error("loaded field moved");
  cover property ($rose(core_release));
  cover property ($rose(reset_pin_oe));
  cover property ($fell(memory_unlocked));
endmodule : fcl_top_properties

// file: verification/tb_top.sv
// Purpose: Self-checking bench of the fuse configuration loader
// Assumes: Four cycles stand for one millisecond of start-up delay
// Notes: Fuse rows first, then lock, refusal and pin guard cases
module tb_top
  import fcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] cal16_val = 16'h3C21; // Arbitrary factory pair
  localparam logic [15:0] cal20_val = 16'h4D32;
  // Fuse inputs, chosen pair and release edge they should give
  typedef struct packed {
    logic [7:0] wdt, bod, osc, cmp, sys, startup_delay_select;
    logic [15:0] cal;
    logic [8:0] rel;
  } fcl_row_t;
  fcl_row_t rows [4] = '{
    '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, cal16_val, 9'h002},
    '{8'h5A, 8'h55, 8'h82, 8'hA5, 8'h45, 8'h03, cal20_val, 9'h012},
    '{8'hF1, 8'hEA, 8'h01, 8'hFF, 8'h89, 8'h07, cal16_val, 9'h102},
    '{8'h0F, 8'h1C, 8'h02, 8'h5A, 8'hC1, 8'h01, cal20_val, 9'h006}
  };
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, slow_osc, gpio_out = 1'b0, gpio_oe = 1'b1;
  fcl_bank_t bank_in = '0, fuse_bank;
  logic [15:0] factory_cal_16m, factory_cal_20m;
  logic [3:0] wdt_window;
  logic [1:0] brownout_active_mode, reset_pin_role;
  logic [7:0] coarse_calibration, temperature_calibration, fault_control_reg;
  logic [7:0] boot_section_end, app_section_end;
  logic reset_pin_out, reset_pin_oe, crc_scan_enable, memory_unlocked;
  logic eeprom_keep_on_erase, core_release;
  int error_cnt = 0, checked = 0, cyc = 0;
  fcl_fuse_model #(.CAL16(cal16_val), .CAL20(cal20_val)) model_u (
    .pclk, .bank_in, .fuse_bank, .factory_cal_16m, .factory_cal_20m, .slow_osc);
  fcl_top #(.MS_CYCLES(4)) dut_u (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .fuse_bank, .factory_cal_16m, .factory_cal_20m, .slow_osc, .gpio_out,
    .gpio_oe, .reset_pin_out, .reset_pin_oe, .wdt_window, .wdt_period(),
    .brownout_threshold(), .brownout_sample_rate(), .brownout_active_mode,
    .brownout_sleep_mode(), .calibration_lock(), .oscillator_frequency_select(),
    .coarse_calibration, .temperature_calibration, .fault_control_reg,
    .compare_pin_enable(), .compare_default_level(), .crc_source_select(),
    .crc_scan_enable, .reset_pin_role, .boot_section_end, .app_section_end,
    .memory_unlocked, .eeprom_keep_on_erase, .core_release);
  always #10 pclk = ~pclk;
  // Cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Reset with a row's fuses, then count edges to core release
  task automatic do_reset(input fcl_row_t r);
    int n;
    @(posedge pclk);
    presetn <= 1'b0;
    bank_in <= {8'hC5, 8'h00, r.bod, r.wdt, r.startup_delay_select, r.sys, r.cmp, 8'h00, r.osc, r.bod, r.wdt};
    repeat (12) @(posedge pclk);
    chk(core_release, 1'b0);
    chk(wdt_window, 4'h0);
    presetn <= 1'b1;
    n = 0;
    @(negedge pclk);
    while (core_release !== 1'b1 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    chk(n, r.rel);
  endtask : do_reset
  initial begin
    int n;
    for (int i = 0; i < 4; i++) begin
      do_reset(rows[i]);
      chk(wdt_window, rows[i].wdt[7:4]);
      chk(brownout_active_mode, rows[i].bod[3:2]);
      chk({temperature_calibration, coarse_calibration}, rows[i].cal);
      chk(fault_control_reg, rows[i].cmp);
      chk(reset_pin_role, rows[i].sys[3:2]);
      chk(boot_section_end, rows[i].bod);
      chk(app_section_end, rows[i].wdt);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, {24'h0, rows[i].wdt});
      @(negedge pclk);
      chk(crc_scan_enable, rows[i].sys[7:6] != 2'h3);
      chk(memory_unlocked, 1'b1);
    end
    // Last row: pin in I/O role, save bit set
    chk(eeprom_keep_on_erase, 1'b1);
    chk(reset_pin_oe, 1'b0);
    apb(1'b1, 12'h028, 32'h3A);
    chk(er, 1'b0);
    apb(1'b0, 12'h028, 32'h0);
    chk(rd, 32'h3A);
    @(negedge pclk);
    chk(memory_unlocked, 1'b0);
    chk(eeprom_keep_on_erase, 1'b0);
    // Reserved index and a write to a read-only fuse are refused
    apb(1'b0, 12'h00C, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, 12'h000, 32'hFF);
    chk(er, 1'b1);
    apb(1'b1, 12'h028, 32'hC5);
    bank_in[0] <= 8'h99;
    n = 0;
    while (reset_pin_oe !== 1'b1 && n < 4000) begin
      @(negedge pclk);
      n++;
    end
    chk(reset_pin_oe, 1'b1);
    chk(n > 500, 1'b1);
    chk(wdt_window, rows[3].wdt[7:4]);
    @(posedge pclk);
    gpio_out <= 1'b1;
    gpio_oe <= 1'b0;
    repeat (2) @(negedge pclk);
    chk(reset_pin_out, 1'b1);
    chk(reset_pin_oe, 1'b0);
    apb(1'b0, 12'h030, 32'h0);
    chk(rd, 32'h7);
    tally_and_finish();
  end
endmodule : tb_top

bind fcl_top fcl_top_properties chk_u (
  .pclk, .presetn, .penable, .pready, .fuse_bank, .factory_cal_16m, .factory_cal_20m,
  .slow_osc, .reset_pin_oe, .reset_pin_role, .wdt_window, .wdt_period,
  .brownout_threshold, .brownout_sample_rate, .brownout_active_mode,
  .brownout_sleep_mode, .calibration_lock, .oscillator_frequency_select,
  .coarse_calibration, .temperature_calibration, .fault_control_reg,
  .compare_pin_enable, .compare_default_level, .crc_source_select,
  .crc_scan_enable, .memory_unlocked, .eeprom_keep_on_erase, .core_release);
